// File: logic/gposcs_top.v
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
`include "gposcs_defines.vh"
// Notes on behaviour
// - Bits 14..8 hold a short flag per pad 6..0, set on sense/command mismatch.
// - Summary pad short fault output is the OR of all seven short flags.
// - Bits 6..0 hold open-load flags, re-set while switch closed and open persists.
// - Flags and counter reset to zero; writing 0 clears, writing 1 keeps.
// - Second register holds an 8-bit link error count in bits 15..8.
// - A count of zero means no link error since clear or power-on.
module gposcs_top (
	// Clock and reset
	input wire sys_clk,
	input wire rst_b,
	// AXI4-Lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Pad command and sensed pad level
	input wire [6:0] pad_cmd,
	input wire [6:0] pad_sense_pin,
	// Open-load detection
	input wire open_det_switch_closed,
	input wire [6:0] an_open_pin,
	// Link error event, one pulse per error
	input wire comm_err_evt,
	// Summary fault outputs
	output reg any_pad_short_fault,
	output reg any_analog_open_fault,
	output reg link_error_overflow_fault,
	// Interrupt
	output reg irq
);

// Flag storage
reg [6:0] pad_short_flag_ff;
reg [6:0] an_open_flag_ff;
reg [6:0] nxt_pad_short_flag;
reg [6:0] nxt_an_open_flag;

// Synchronised pins and live conditions
wire [6:0] pad_sense_sync;
wire [6:0] an_open_sync;
wire [6:0] short_now;
wire [6:0] open_now;

// Interrupt registers
reg [3:0] irq_sts_ff;
reg [3:0] irq_mask_ff;
reg [3:0] nxt_irq_sts;
reg [3:0] nxt_irq_mask;
reg [3:0] irq_set;

// Write channel state
reg aw_hold_ff;
reg w_hold_ff;
reg [5:0] aw_idx_ff;
reg [31:0] w_data_ff;
reg [3:0] w_strb_ff;
wire aw_take;
wire w_take;
wire wr_go;

// Read channel
wire ar_take;
wire [5:0] ar_idx;
reg [31:0] rd_mux;
reg rd_hit;

// Write decode and clear masks
reg [15:0] wr_lane16;
reg [15:0] keep_pad;
reg [15:0] keep_comm;
reg [3:0] irq_clr;
reg wr_hit;

// Counter
wire [7:0] err_cnt;
wire err_ovf;

// Per-bit synchronisers and live fault conditions
genvar gi;
generate
	for (gi = 0; gi < 7; gi = gi + 1) begin : g_bit
		gposcs_sync u_sense_sync (
			.sys_clk(sys_clk),
			.rst_b(rst_b),
			.async_in(pad_sense_pin[gi]),
			.level_ff(pad_sense_sync[gi])
		);
		gposcs_sync u_open_sync (
			.sys_clk(sys_clk),
			.rst_b(rst_b),
			.async_in(an_open_pin[gi]),
			.level_ff(an_open_sync[gi])
		);
		// Mismatch between commanded and sensed level
		assign short_now[gi] = pad_sense_sync[gi] ^ pad_cmd[gi];
		// Open load counts only while the detect switch is closed
		assign open_now[gi] = an_open_sync[gi] & open_det_switch_closed;
	end
endgenerate

// Channel handshakes
assign aw_take = s_axi_awvalid & s_axi_awready;
assign w_take = s_axi_wvalid & s_axi_wready;
assign ar_take = s_axi_arvalid & s_axi_arready;
assign wr_go = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
assign ar_idx = s_axi_araddr[7:2];

// Address and data capture, in either order
always @(posedge sys_clk or negedge rst_b) begin
	if (!rst_b) begin
		aw_hold_ff <= 1'b0;
		w_hold_ff <= 1'b0;
		aw_idx_ff <= 6'h00;
		w_data_ff <= 32'h00000000;
		w_strb_ff <= 4'h0;
	end else begin
		if (aw_take) begin
			aw_hold_ff <= 1'b1;
			aw_idx_ff <= s_axi_awaddr[7:2];
		end else if (wr_go) begin
			aw_hold_ff <= 1'b0;
		end
		if (w_take) begin
			w_hold_ff <= 1'b1;
			w_data_ff <= s_axi_wdata;
			w_strb_ff <= s_axi_wstrb;
		end else if (wr_go) begin
			w_hold_ff <= 1'b0;
		end
	end
end

// Ready and response for the write path
always @(posedge sys_clk or negedge rst_b) begin
	if (!rst_b) begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `GPOSCS_RESP_OKAY;
	end else begin
		if (aw_take) begin
			s_axi_awready <= 1'b0;
		end else if (s_axi_bvalid & s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
		if (w_take) begin
			s_axi_wready <= 1'b0;
		end else if (s_axi_bvalid & s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
		if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `GPOSCS_RESP_OKAY : `GPOSCS_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// Write decode: a zero in an enabled byte lane clears flags and count, a one clears interrupt status bits; disabled lanes keep
always @* begin
	wr_lane16 = {{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
	keep_pad = 16'hFFFF;
	keep_comm = 16'hFFFF;
	irq_clr = 4'h0;
	nxt_irq_mask = irq_mask_ff;
	wr_hit = 1'b0;
	case (aw_idx_ff)
		`GPOSCS_IDX_PAD_OPEN: begin
			wr_hit = 1'b1;
			if (wr_go) begin
				keep_pad = w_data_ff[15:0] | ~wr_lane16;
			end
		end
		`GPOSCS_IDX_COMM: begin
			wr_hit = 1'b1;
			if (wr_go) begin
				keep_comm = w_data_ff[15:0] | ~wr_lane16;
			end
		end
		`GPOSCS_IDX_IRQ_STS: begin
			wr_hit = 1'b1;
			if (wr_go & w_strb_ff[0]) begin
				irq_clr = w_data_ff[3:0];
			end
		end
		`GPOSCS_IDX_IRQ_MASK: begin
			wr_hit = 1'b1;
			if (wr_go & w_strb_ff[0]) begin
				nxt_irq_mask = w_data_ff[3:0];
			end
		end
		default: begin
			wr_hit = 1'b0;
		end
	endcase
end

// Flag update: clear by mask, then a live condition sets again
always @* begin
	nxt_pad_short_flag = (pad_short_flag_ff
		& keep_pad[`GPOSCS_SHORT_MSB:`GPOSCS_SHORT_LSB]) | short_now;
	nxt_an_open_flag = (an_open_flag_ff
		& keep_pad[`GPOSCS_OPEN_MSB:`GPOSCS_OPEN_LSB]) | open_now;
end

// Flag registers
always @(posedge sys_clk or negedge rst_b) begin
	if (!rst_b) begin
		pad_short_flag_ff <= `GPOSCS_RST_FLAGS;
		an_open_flag_ff <= `GPOSCS_RST_FLAGS;
	end else begin
		pad_short_flag_ff <= nxt_pad_short_flag;
		an_open_flag_ff <= nxt_an_open_flag;
	end
end

// Saturating link error counter
gposcs_err_cnt u_err_cnt (
	.sys_clk(sys_clk),
	.rst_b(rst_b),
	.err_evt(comm_err_evt),
	.keep_mask(keep_comm[`GPOSCS_CNT_MSB:`GPOSCS_CNT_LSB]),
	.cnt_ff(err_cnt),
	.ovf_ff(err_ovf)
);

// Interrupt events: a flag newly raised, a link error, an overflow attempt
always @* begin
	irq_set = 4'h0;
	irq_set[`GPOSCS_IRQ_SHORT] = |(short_now & ~pad_short_flag_ff);
	irq_set[`GPOSCS_IRQ_OPEN] = |(open_now & ~an_open_flag_ff);
	irq_set[`GPOSCS_IRQ_COMM] = comm_err_evt;
	irq_set[`GPOSCS_IRQ_OVF] = err_ovf;
	nxt_irq_sts = (irq_sts_ff & ~irq_clr) | irq_set;
end

// Interrupt status, mask and output level
always @(posedge sys_clk or negedge rst_b) begin
	if (!rst_b) begin
		irq_sts_ff <= `GPOSCS_RST_IRQ;
		irq_mask_ff <= `GPOSCS_RST_IRQ;
		irq <= 1'b0;
	end else begin
		irq_sts_ff <= nxt_irq_sts;
		irq_mask_ff <= nxt_irq_mask;
		irq <= |(nxt_irq_sts & nxt_irq_mask);
	end
end

// Short and open summary outputs follow the flags without extra delay; the overflow output lags err_ovf by one cycle
always @(posedge sys_clk or negedge rst_b) begin
	if (!rst_b) begin
		any_pad_short_fault <= 1'b0;
		any_analog_open_fault <= 1'b0;
		link_error_overflow_fault <= 1'b0;
	end else begin
		any_pad_short_fault <= |nxt_pad_short_flag;
		any_analog_open_fault <= |nxt_an_open_flag;
		// One-cycle pulse passed on as is; only the interrupt status register latches it
		link_error_overflow_fault <= err_ovf;
	end
end

// Read data selection; reserved bits read as zero
always @* begin
	rd_mux = 32'h00000000;
	rd_hit = 1'b1;
	case (ar_idx)
		`GPOSCS_IDX_PAD_OPEN: begin
			rd_mux[`GPOSCS_SHORT_MSB:`GPOSCS_SHORT_LSB] = pad_short_flag_ff;
			rd_mux[`GPOSCS_OPEN_MSB:`GPOSCS_OPEN_LSB] = an_open_flag_ff;
		end
		`GPOSCS_IDX_COMM: begin
			rd_mux[`GPOSCS_CNT_MSB:`GPOSCS_CNT_LSB] = err_cnt;
		end
		`GPOSCS_IDX_IRQ_STS: begin
			rd_mux[3:0] = irq_sts_ff;
		end
		`GPOSCS_IDX_IRQ_MASK: begin
			rd_mux[3:0] = irq_mask_ff;
		end
		default: begin
			rd_hit = 1'b0;
		end
	endcase
end

// Read channel: one read under way, answer one cycle after the address
always @(posedge sys_clk or negedge rst_b) begin
	if (!rst_b) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `GPOSCS_RESP_OKAY;
	end else begin
		if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_hit ? `GPOSCS_RESP_OKAY : `GPOSCS_RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
		end
	end
end

endmodule // gposcs_top

// File: logic/gposcs_defines.vh
`ifndef GPOSCS_DEFINES_VH
`define GPOSCS_DEFINES_VH

// Bus geometry
`define GPOSCS_ADDR_W 8
`define GPOSCS_IDX_W 6

// Register indices; byte address is four times the index
`define GPOSCS_IDX_PAD_OPEN 6'h21
`define GPOSCS_IDX_COMM 6'h23
`define GPOSCS_IDX_IRQ_STS 6'h30
`define GPOSCS_IDX_IRQ_MASK 6'h31

// Field positions
`define GPOSCS_SHORT_LSB 8
`define GPOSCS_SHORT_MSB 14
`define GPOSCS_OPEN_LSB 0
`define GPOSCS_OPEN_MSB 6
`define GPOSCS_CNT_LSB 8
`define GPOSCS_CNT_MSB 15

// Interrupt status bit positions
`define GPOSCS_IRQ_SHORT 0
`define GPOSCS_IRQ_OPEN 1
`define GPOSCS_IRQ_COMM 2
`define GPOSCS_IRQ_OVF 3

// Reset values and limits
`define GPOSCS_RST_FLAGS 7'h00
`define GPOSCS_RST_CNT 8'h00
`define GPOSCS_RST_IRQ 4'h0
`define GPOSCS_CNT_MAX 8'hFF

// Bus responses
`define GPOSCS_RESP_OKAY 2'h0
`define GPOSCS_RESP_SLVERR 2'h2

`endif

// File: logic/gposcs_sync.v
`timescale 1ns/10ps
// Three-stage synchroniser with a two-sample agreement filter
module gposcs_sync (
	// Clock and reset
	input wire sys_clk,
	input wire rst_b,
	// Asynchronous level in, filtered level out
	input wire async_in,
	output reg level_ff
);

reg s1_ff;
reg s2_ff;
reg s3_ff;

// Stage one only feeds stage two; output moves when stages two and three agree
always @(posedge sys_clk or negedge rst_b) begin
	if (!rst_b) begin
		s1_ff <= 1'b0;
		s2_ff <= 1'b0;
		s3_ff <= 1'b0;
		level_ff <= 1'b0;
	end else begin
		s1_ff <= async_in;
		s2_ff <= s1_ff;
		s3_ff <= s2_ff;
		if (s2_ff == s3_ff) begin
			level_ff <= s3_ff;
		end
	end
end

endmodule // gposcs_sync

// File: logic/gposcs_err_cnt.v
`timescale 1ns/10ps
`include "gposcs_defines.vh"
// Saturating link error counter with write-zero-to-clear bits
module gposcs_err_cnt (
	// Clock and reset
	input wire sys_clk,
	input wire rst_b,
	// Error event and clear mask (zero bits clear)
	input wire err_evt,
	input wire [7:0] keep_mask,
	// Count and overflow attempt pulse
	output reg [7:0] cnt_ff,
	output reg ovf_ff
);

reg [7:0] base;
reg [7:0] nxt_cnt;
reg nxt_ovf;

// Clear first, then count, so an error in the clear cycle is kept
always @* begin
	base = cnt_ff & keep_mask;
	nxt_cnt = base;
	nxt_ovf = 1'b0;
	if (err_evt) begin
		if (base == `GPOSCS_CNT_MAX) begin
			nxt_ovf = 1'b1;
		end else begin
			nxt_cnt = base + 8'h01;
		end
	end
end

// Count register; zero means no error since clear or power-on
always @(posedge sys_clk or negedge rst_b) begin
	if (!rst_b) begin
		cnt_ff <= `GPOSCS_RST_CNT;
		ovf_ff <= 1'b0;
	end else begin
		cnt_ff <= nxt_cnt;
		ovf_ff <= nxt_ovf;
	end
end

endmodule // gposcs_err_cnt

// File: sim/gposcs_chk_assertions.sv
`timescale 1ns/10ps
// Port checks for the pad and link status bank
module gposcs_chk (
	// Clock and reset
	input logic sys_clk,
	input logic rst_b,
	// Bus handshakes
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic [31:0] s_axi_rdata,
	// Detection and faults
	input logic [6:0] pad_cmd,
	input logic [6:0] pad_sense_pin,
	input logic open_det_switch_closed,
	input logic [6:0] an_open_pin,
	input logic comm_err_evt,
	input logic any_pad_short_fault,
	input logic any_analog_open_fault,
	input logic link_error_overflow_fault
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Steady conditions that must raise a flag
	sequence s_sh;
		pad_sense_pin != pad_cmd && $stable(pad_sense_pin) && $stable(pad_cmd);
	endsequence
	sequence s_op;
		open_det_switch_closed && an_open_pin != 7'h00 && $stable(an_open_pin);
	endsequence
	property p_short;
		s_sh [*7] |-> any_pad_short_fault;
	endproperty
	a_short: assert property (p_short) else $error("no short");
	property p_open;
		s_op [*7] |-> any_analog_open_fault;
	endproperty
	a_open: assert property (p_open) else $error("no open");
	property p_clr;
		$fell(any_pad_short_fault) || $fell(any_analog_open_fault) |-> $rose(s_axi_bvalid);
	endproperty
	a_clr: assert property (p_clr) else $error("bad clear");
	property p_ovf;
		link_error_overflow_fault |-> $past(comm_err_evt, 2);
	endproperty
	a_ovf: assert property (p_ovf) else $error("bad ovf");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bhold: assert property (p_bhold) else $error("b dropped");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("r dropped");
	property p_rlat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rlat: assert property (p_rlat) else $error("r late");
	property p_rdone;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_rdone: assert property (p_rdone) else $error("r stuck");
endmodule // gposcs_chk

bind gposcs_top gposcs_chk u_chk (.sys_clk, .rst_b, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.pad_cmd, .pad_sense_pin, .open_det_switch_closed, .an_open_pin, .comm_err_evt,
	.any_pad_short_fault, .any_analog_open_fault, .link_error_overflow_fault);

// File: sim/test_gpio_open_short_comm_error_status.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
	$display("[ERR] %0t %h %h", $time, a, e); end end
module test_gpio_open_short_comm_error_status;
	logic sys_clk = '0;
	logic rst_b = '0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0;
	logic [6:0] pad_cmd = '0, pad_sense_pin = '0, an_open_pin = '0, r;
	logic open_det_switch_closed = '0, comm_err_evt = '0;
	wire [31:0] s_axi_rdata;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	wire any_pad_short_fault, any_analog_open_fault, link_error_overflow_fault;
	int miscompares = 0, checks_done = 0, ovf_n = 0, n;
	logic [33:0] qr[$];
	logic [1:0] qb[$];

	gposcs_top uut (.*);

	// Free running clock
	initial forever #10 sys_clk = ~sys_clk;

	task give_verdict;
		if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask

	// Write with expected response noted
	task wr(input [7:0] a, input [31:0] d, input [1:0] rs);
		int t;
		qb.push_back(rs);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		t = 0;
		do begin
			@(posedge sys_clk);
			t++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) s_axi_bready <= 1'b0;
			if (t > 99) begin miscompares++; give_verdict; end
		end while (s_axi_bready);
	endtask

	// Read with expected response and data noted
	task rd(input [7:0] a, input [33:0] x);
		int t;
		qr.push_back(x);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		t = 0;
		// Ready comes one cycle after valid, so the data must stand while it waits
		do begin
			@(posedge sys_clk);
			t++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) s_axi_rready <= ~s_axi_rready;
			if (t > 99) begin miscompares++; give_verdict; end
		end while (!(s_axi_rvalid && s_axi_rready));
	endtask

	task pulse(input int k);
		repeat (k) begin
			comm_err_evt <= 1'b1;
			@(posedge sys_clk);
			comm_err_evt <= 1'b0;
			@(posedge sys_clk);
		end
	endtask

	// Compare bus answers with the oldest note
	always @(posedge sys_clk) begin : b_mon
		logic [33:0] er;
		logic [1:0] eb;
		// Take each note off once, so a mismatch does not eat the next one
		if (s_axi_rvalid && s_axi_rready) begin
			er = qr.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata}, er)
		end
		if (s_axi_bvalid && s_axi_bready) begin
			eb = qb.pop_front();
			`CHK(s_axi_bresp, eb)
		end
	end

	// Count overflow pulses
	always @(posedge sys_clk) if (link_error_overflow_fault) ovf_n++;

	// Main sequence
	initial begin
		n = $urandom(43);
		tick(6);
		rst_b <= 1'b1;
		tick(2);
		rd(8'h84, 34'h0);
		rd(8'h8C, 34'h0);
		wr(8'h88, 32'hFFFFFFFF, 2'h2);
		rd(8'h88, {2'h2, 32'h0});
		wr(8'hC4, 32'hF, 2'h0);
		rd(8'hC4, 34'hF);
		r = $urandom;
		pad_cmd <= r;
		pad_sense_pin <= r;
		tick(8);
		// Command leads the synchronised sense, so drop the flags of that transient
		wr(8'h84, 32'h0, 2'h0);
		rd(8'h84, 34'h0);
		for (int i = 0; i < 7; i++) begin
			pad_sense_pin <= r ^ (7'h01 << i);
			tick(8);
			pad_sense_pin <= r;
			tick(8);
			`CHK(any_pad_short_fault, 1'b1)
			rd(8'h84, {18'h0, 7'h7F >> (6 - i), 8'h00});
		end
		`CHK(irq, 1'b1)
		wr(8'h84, 32'h0800, 2'h0);
		rd(8'h84, 34'h0800);
		wr(8'h84, 32'h0, 2'h0);
		`CHK(any_pad_short_fault, 1'b0)
		wr(8'hC0, 32'hF, 2'h0);
		`CHK(irq, 1'b0)
		r = $urandom;
		r[0] = 1'b1;
		an_open_pin <= r;
		tick(8);
		rd(8'h84, 34'h0);
		open_det_switch_closed <= 1'b1;
		tick(8);
		wr(8'h84, 32'h0, 2'h0);
		rd(8'h84, {27'h0, r});
		`CHK(any_analog_open_fault, 1'b1)
		an_open_pin <= 7'h00;
		tick(8);
		wr(8'h84, 32'h0, 2'h0);
		rd(8'h84, 34'h0);
		wr(8'hC0, 32'hF, 2'h0);
		n = 1 + $urandom % 20;
		pulse(n);
		rd(8'h8C, {18'h0, n[7:0], 8'h00});
		wr(8'h8C, 32'h0, 2'h0);
		rd(8'h8C, 34'h0);
		pulse(257);
		rd(8'h8C, 34'hFF00);
		`CHK(ovf_n, 2)
		wr(8'h8C, 32'hF000, 2'h0);
		rd(8'h8C, 34'hF000);
		rd(8'hC0, 34'hC);
		`CHK(irq, 1'b1)
		wr(8'hC4, 32'h0, 2'h0);
		`CHK(irq, 1'b0)
		wr(8'hC0, 32'hF, 2'h0);
		rd(8'hC0, 34'h0);
		give_verdict;
	end
endmodule // test_gpio_open_short_comm_error_status
